// ### rtl/fifo_dma_channel_ctrl_status.sv
`timescale 1ns/10ps

module fifo_dma_channel_ctrl_status
    import chan_ctrl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_ce,
    // Register port
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic [31:0]         i_reg_wdata,
    output logic      [31:0]         o_reg_rdata,
    output logic                     o_reg_rvalid,
    // FIFO chain state
    input  wire fifo_flags_t         i_flags,
    input  wire logic [31:0]         i_tx_chain_count,
    input  wire logic [31:0]         i_rx_chain_count,
    input  wire logic [31:0]         i_rx_fifo_count,
    input  wire logic [2:0]          i_rx_pipe_count,
    input  wire logic [31:0]         i_tx_ae_level,
    input  wire logic [31:0]         i_rx_af_level,
    input  wire logic                i_rx_load_wr,
    output logic      [31:0]         o_rx_data_count,
    // DMA engine
    input  wire dma_evt_t            i_dma,
    output logic                     o_tx_dma_urgent,
    output logic                     o_rx_dma_urgent,
    output logic                     o_irq,
    // Serial state machines and clocking
    input  wire logic                i_tx_enable,
    input  wire logic                i_rx_enable,
    input  wire logic                i_transmit_sm_idle,
    input  wire logic                i_receive_sm_idle,
    input  wire logic                i_tx_ref_locked,
    input  wire logic                i_internal_receive_hold,
    output logic                     o_tx_fifo_rst,
    output logic                     o_rx_fifo_rst,
    output logic                     o_clock_monitor_rst,
    output logic                     o_receive_hold_output,
    // SDRAM controller
    input  wire logic                i_sdram_busy,
    input  wire logic                i_sdram_init_done,
    output logic                     o_sdram_init_start,
    output logic                     o_mem_a_param_sel,
    output logic                     o_tx_direct_mover_enable,
    output logic                     o_rx_direct_mover_enable,
    // Loopback mover, TX FIFO side
    input  wire logic                i_lb_tx_valid,
    input  wire logic [LB_WIDTH-1:0] i_lb_tx_data,
    output logic                     o_lb_tx_pop,
    // Loopback mover, RX FIFO side
    output logic                     o_lb_rx_valid,
    output logic      [LB_WIDTH-1:0] o_lb_rx_data,
    input  wire logic                i_lb_rx_ready
);

    // Latch update: hardware set wins over a software clear
    function automatic logic w1c(input logic cur, input logic set, input logic clr);
        w1c = set | (cur & ~clr);
    endfunction

    logic [31:0]         ctrl_q;
    logic [31:0]         ctrl_d;
    logic [LAT_NUM-1:0]  lat_q;
    logic [LAT_NUM-1:0]  lat_set;
    logic [LAT_NUM-1:0]  lat_clr;
    logic                ovf_q;
    logic                tx_empty_q;
    logic                tx_ae_q;
    logic                rx_af_q;
    logic                init_start_q;
    mon_state_t          mon_q;
    logic [15:0]         mon_cnt_q;
    logic [31:0]         status;
    logic [31:0]         rdata_d;

    // Address decode
    wire ctrl_sel   = (i_reg_addr == CTRL_OFFSET);
    wire status_sel = (i_reg_addr == STATUS_OFFSET);
    wire ctrl_wr    = i_ce & i_reg_wr & ctrl_sel;
    wire status_wr  = i_ce & i_reg_wr & status_sel;

    // Live FIFO chain flags
    wire tx_empty   = i_flags.tx_dma_empty & i_flags.sdram_tx_empty
                    & i_flags.sdram_io_tx_empty & i_flags.tx_io_empty;
    wire tx_aempty  = (i_tx_chain_count < i_tx_ae_level);
    wire tx_full    = i_flags.tx_dma_full;
    wire rx_empty   = i_flags.rx_dma_empty;
    wire rx_full    = i_flags.rx_dma_full;
    wire rx_afull   = (i_rx_chain_count >= i_rx_af_level);

    // Control field taps
    wire loopback   = ctrl_q[CTRL_LOOPBACK];
    wire ch_ie      = ctrl_q[CTRL_CH_IE];
    wire force_irq  = ctrl_q[CTRL_FORCE_IRQ];
    wire init_req   = ctrl_wr & i_reg_wdata[CTRL_SDRAM_INIT]
                    & ~ctrl_q[CTRL_SDRAM_INIT] & ~i_sdram_busy;

    // Control register next value; init bit is set-only from software
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = (ctrl_q & ~CTRL_RW_MASK) | (i_reg_wdata & CTRL_RW_MASK);
        end
        if (init_req) begin
            ctrl_d[CTRL_SDRAM_INIT] = 1'b1;
        end else if (i_sdram_init_done) begin
            ctrl_d[CTRL_SDRAM_INIT] = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (i_ce) begin
            ctrl_q <= ctrl_d;
        end
    end

    // Init kick is one cycle wide so the controller sees a single request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            init_start_q <= 1'b0;
        end else if (i_ce) begin
            init_start_q <= init_req;
        end
    end

    // Edge history for the sticky flags
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_empty_q <= 1'b1;
            tx_ae_q    <= 1'b1;                                         // Empty chain is almost empty
            rx_af_q    <= 1'b0;
        end else if (i_ce) begin
            tx_empty_q <= tx_empty;
            tx_ae_q    <= tx_aempty;
            rx_af_q    <= rx_afull;
        end
    end

    // Sticky event sources
    assign lat_set[LAT_TX_LVL]  = tx_aempty & ~tx_ae_q;
    assign lat_set[LAT_RX_LVL]  = rx_afull & ~rx_af_q;
    assign lat_set[LAT_WR_ERR]  = i_dma.wr_err;
    assign lat_set[LAT_RD_ERR]  = i_dma.rd_err;
    assign lat_set[LAT_WR_INT]  = i_dma.wr_done;
    assign lat_set[LAT_RD_INT]  = i_dma.rd_done;
    assign lat_set[LAT_TX_DONE] = tx_empty & ~tx_empty_q;
    assign lat_clr = status_wr ? i_reg_wdata[ST_LAT_LO +: LAT_NUM]
                               : {LAT_NUM{1'b0}};

    // One write-one-to-clear latch per status bit
    genvar gi;
    generate
        for (gi = 0; gi < LAT_NUM; gi = gi + 1) begin : g_lat
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    lat_q[gi] <= 1'b0;
                end else if (i_ce) begin
                    lat_q[gi] <= w1c(lat_q[gi], lat_set[gi], lat_clr[gi]);
                end
            end
        end
    endgenerate

    // Overflow latch sits apart from the contiguous group
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ovf_q <= 1'b0;
        end else if (i_ce) begin
            ovf_q <= w1c(ovf_q, i_rx_load_wr & rx_full,
                         status_wr & i_reg_wdata[ST_OVERFLOW]);
        end
    end

    // Interrupt combine; local sum is taken before the channel enable
    wire local_irq = (lat_q[LAT_TX_DONE] & ctrl_q[CTRL_TX_DONE_IE])
                   | (lat_q[LAT_RX_LVL] & ctrl_q[CTRL_RX_LVL_IE])
                   | (lat_q[LAT_TX_LVL] & ctrl_q[CTRL_TX_LVL_IE])
                   | force_irq;
    wire ch_irq    = ch_ie & local_irq;
    wire wr_irq    = ctrl_q[CTRL_WR_DMA_IE] & lat_q[LAT_WR_INT];
    wire rd_irq    = ctrl_q[CTRL_RD_DMA_IE] & lat_q[LAT_RD_INT];
    wire any_irq   = ch_irq | wr_irq | rd_irq;

    // Status word assembly
    always_comb begin
        status = 32'h0000_0000;
        status[ST_TX_EMPTY]     = tx_empty;
        status[ST_TX_AEMPTY]    = tx_aempty;
        status[ST_TX_FULL]      = tx_full;
        status[ST_RX_EMPTY]     = rx_empty;
        status[ST_RX_AFULL]     = rx_afull;
        status[ST_RX_FULL]      = rx_full;
        status[ST_TX_AE_LIVE]   = tx_aempty & ctrl_q[CTRL_TX_LVL_IE];
        status[ST_RX_AF_LIVE]   = rx_afull & ctrl_q[CTRL_RX_LVL_IE];
        status[ST_LAT_LO +: LAT_NUM] = lat_q;
        status[ST_OVERFLOW]     = ovf_q;
        status[ST_RX_SM_IDLE]   = i_receive_sm_idle;
        status[ST_TX_SM_IDLE]   = i_transmit_sm_idle;
        status[ST_DMA_OUT_IDLE] = i_dma.dma_out_idle;
        status[ST_DMA_IN_IDLE]  = i_dma.dma_in_idle;
        status[ST_LOCKED]       = i_tx_ref_locked;
        status[ST_LOCAL_IRQ]    = local_irq;
        status[ST_IRQ]          = any_irq;
    end

    // Read mux; unmapped offsets answer zero
    assign rdata_d = ctrl_sel   ? ctrl_q :
                     status_sel ? status : 32'h0000_0000;

    // Read data is registered, valid one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata  <= 32'h0000_0000;
            o_reg_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_d;
            end
        end
    end

    // Lock monitor: software pulse or automatic retry after a dry spell
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mon_q     <= MON_RUN;
            mon_cnt_q <= 16'h0000;
        end else if (i_ce) begin
            case (mon_q)
                MON_RUN: begin
                    mon_cnt_q <= 16'h0000;
                    if (!i_tx_ref_locked) begin
                        mon_q <= MON_WAIT;
                    end
                end
                MON_WAIT: begin
                    if (i_tx_ref_locked) begin
                        mon_q <= MON_RUN;
                    end else if (mon_cnt_q == 16'(RETRY_CYCLES - 1)) begin
                        mon_q     <= MON_PULSE;
                        mon_cnt_q <= 16'h0000;
                    end else begin
                        mon_cnt_q <= mon_cnt_q + 16'h0001;
                    end
                end
                MON_PULSE: begin
                    if (mon_cnt_q == 16'(MON_PULSE_CYCLES - 1)) begin
                        mon_q     <= MON_WAIT;
                        mon_cnt_q <= 16'h0000;
                    end else begin
                        mon_cnt_q <= mon_cnt_q + 16'h0001;
                    end
                end
                default: begin
                    mon_q     <= MON_RUN;
                    mon_cnt_q <= 16'h0000;
                end
            endcase
        end
    end

    // Loopback buffer; two entries keep the mover streaming under a stall
    logic [LB_WIDTH-1:0] lb_mem [LB_DEPTH];
    logic                lb_wp_q;
    logic                lb_rp_q;
    logic [1:0]          lb_cnt_q;

    wire lb_active = loopback & ~i_tx_enable & ~i_rx_enable;
    wire lb_flush  = ~lb_active | ctrl_q[CTRL_TX_RST] | ctrl_q[CTRL_RX_RST];
    wire lb_ready  = (lb_cnt_q != 2'(LB_DEPTH)) & ~lb_flush;
    wire lb_push   = i_lb_tx_valid & lb_ready;
    wire lb_pop    = o_lb_rx_valid & i_lb_rx_ready;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lb_wp_q  <= 1'b0;
            lb_rp_q  <= 1'b0;
            lb_cnt_q <= 2'h0;
        end else if (i_ce) begin
            if (lb_flush) begin
                lb_wp_q  <= 1'b0;
                lb_rp_q  <= 1'b0;
                lb_cnt_q <= 2'h0;
            end else begin
                lb_wp_q  <= lb_wp_q ^ lb_push;
                lb_rp_q  <= lb_rp_q ^ lb_pop;
                lb_cnt_q <= lb_cnt_q + 2'(lb_push) - 2'(lb_pop);
            end
        end
    end

    // Storage needs no reset; valid is driven only by the count
    always_ff @(posedge i_clk) begin
        if (i_ce && lb_push) begin
            lb_mem[lb_wp_q] <= i_lb_tx_data;
        end
    end

    assign o_lb_tx_pop   = lb_push;
    assign o_lb_rx_valid = (lb_cnt_q != 2'h0);
    assign o_lb_rx_data  = lb_mem[lb_rp_q];

    // Datapath and side controls
    assign o_tx_fifo_rst            = ctrl_q[CTRL_TX_RST];
    assign o_rx_fifo_rst            = ctrl_q[CTRL_RX_RST];
    assign o_clock_monitor_rst      = ctrl_q[CTRL_MON_RST]
                                    | (mon_q == MON_PULSE);
    assign o_receive_hold_output    = ctrl_q[CTRL_FORCE_HOLD]
                                    | i_internal_receive_hold;
    assign o_tx_dma_urgent          = ctrl_q[CTRL_IN_BOOST] & tx_aempty;
    assign o_rx_dma_urgent          = ctrl_q[CTRL_OUT_BOOST] & rx_afull;
    assign o_irq                    = any_irq;
    assign o_sdram_init_start       = init_start_q;
    assign o_mem_a_param_sel        = ctrl_q[CTRL_SDRAM_INIT];
    assign o_tx_direct_mover_enable = ctrl_q[CTRL_TX_DIRECT];
    assign o_rx_direct_mover_enable = ctrl_q[CTRL_RX_DIRECT];
    assign o_rx_data_count          = i_rx_fifo_count
                                    + {29'h0000_0000, i_rx_pipe_count};

endmodule

// ### rtl/chan_ctrl_pkg.sv
package chan_ctrl_pkg;

    // Register map
    localparam logic [7:0]  CTRL_OFFSET   = 8'h50;
    localparam logic [7:0]  STATUS_OFFSET = 8'h54;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // Control bit positions
    localparam int CTRL_TX_RST      = 0;
    localparam int CTRL_RX_RST      = 1;
    localparam int CTRL_LOOPBACK    = 2;
    localparam int CTRL_CH_IE       = 3;
    localparam int CTRL_FORCE_IRQ   = 4;
    localparam int CTRL_WR_DMA_IE   = 5;
    localparam int CTRL_RD_DMA_IE   = 6;
    localparam int CTRL_IN_BOOST    = 7;
    localparam int CTRL_OUT_BOOST   = 8;
    localparam int CTRL_MON_RST     = 9;
    localparam int CTRL_TX_DONE_IE  = 10;
    localparam int CTRL_RX_LVL_IE   = 11;
    localparam int CTRL_TX_LVL_IE   = 12;
    localparam int CTRL_SDRAM_INIT  = 16;
    localparam int CTRL_TX_DIRECT   = 17;
    localparam int CTRL_RX_DIRECT   = 18;
    localparam int CTRL_FORCE_HOLD  = 19;
    localparam logic [31:0] CTRL_RW_MASK = 32'h000E_1FFF;

    // Status bit positions
    localparam int ST_TX_EMPTY   = 0;
    localparam int ST_TX_AEMPTY  = 1;
    localparam int ST_TX_FULL    = 2;
    localparam int ST_RX_EMPTY   = 4;
    localparam int ST_RX_AFULL   = 5;
    localparam int ST_RX_FULL    = 6;
    localparam int ST_TX_AE_LIVE = 8;
    localparam int ST_RX_AF_LIVE = 9;
    localparam int ST_LAT_LO     = 10;
    localparam int ST_DMA_IN_IDLE  = 23;
    localparam int ST_DMA_OUT_IDLE = 22;
    localparam int ST_TX_SM_IDLE   = 21;
    localparam int ST_RX_SM_IDLE   = 20;
    localparam int ST_OVERFLOW   = 19;
    localparam int ST_LOCKED     = 24;
    localparam int ST_LOCAL_IRQ  = 30;
    localparam int ST_IRQ        = 31;

    // Latch vector index, status bit = ST_LAT_LO + index
    localparam int LAT_TX_LVL  = 0;
    localparam int LAT_RX_LVL  = 1;
    localparam int LAT_WR_ERR  = 2;
    localparam int LAT_RD_ERR  = 3;
    localparam int LAT_WR_INT  = 4;
    localparam int LAT_RD_INT  = 5;
    localparam int LAT_TX_DONE = 6;
    localparam int LAT_NUM     = 7;

    // Lock retry timing
    localparam int CLK_MHZ          = 10;
    localparam int RETRY_TIME_US    = 100;
    localparam int RETRY_CYCLES     = RETRY_TIME_US * CLK_MHZ;
    localparam int MON_PULSE_CYCLES = 4;

    // Loopback buffer
    localparam int LB_WIDTH = 32;
    localparam int LB_DEPTH = 2;

    typedef struct packed {
        logic wr_done;
        logic rd_done;
        logic wr_err;
        logic rd_err;
        logic dma_in_idle;
        logic dma_out_idle;
    } dma_evt_t;

    typedef struct packed {
        logic tx_dma_empty;
        logic sdram_tx_empty;
        logic sdram_io_tx_empty;
        logic tx_io_empty;
        logic tx_dma_full;
        logic rx_dma_empty;
        logic rx_dma_full;
    } fifo_flags_t;

    typedef enum logic [1:0] {
        MON_RUN,
        MON_WAIT,
        MON_PULSE
    } mon_state_t;

endpackage

// ### bench/fifo_dma_channel_ctrl_status_checker.sv
`timescale 1ns/10ps
module fifo_dma_channel_ctrl_status_checker
    import chan_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    // Register port
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic        o_reg_rvalid,
    // Counts and levels
    input wire logic [31:0] i_rx_fifo_count,
    input wire logic [2:0]  i_rx_pipe_count,
    input wire logic [31:0] o_rx_data_count,
    input wire logic [31:0] i_tx_chain_count,
    input wire logic [31:0] i_tx_ae_level,
    input wire logic [31:0] i_rx_chain_count,
    input wire logic [31:0] i_rx_af_level,
    input wire logic        o_tx_dma_urgent,
    input wire logic        o_rx_dma_urgent,
    // Loopback, resets, hold, SDRAM
    input wire logic        o_lb_tx_pop,
    input wire logic        i_lb_tx_valid,
    input wire logic        i_tx_enable,
    input wire logic        i_rx_enable,
    input wire logic        o_tx_fifo_rst,
    input wire logic        o_rx_fifo_rst,
    input wire logic        i_internal_receive_hold,
    input wire logic        o_receive_hold_output,
    input wire logic        i_sdram_busy,
    input wire logic        o_sdram_init_start
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Start must be a lone one-cycle pulse
    sequence s_pulse;
        o_sdram_init_start ##1 !o_sdram_init_start;
    endsequence
    property p_init_start;
        o_sdram_init_start |-> $past(i_reg_wr && i_reg_addr == CTRL_OFFSET
            && i_reg_wdata[CTRL_SDRAM_INIT] && !i_sdram_busy);
    endproperty
    a_init_start: assert property (p_init_start) else $error("init start without request");
    property p_init_pulse;
        o_sdram_init_start |-> s_pulse;
    endproperty
    a_init_pulse: assert property (p_init_pulse) else $error("init start too long");
    property p_rvalid;
        i_ce && i_reg_rd |=> o_reg_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_tx_rst;
        $rose(o_tx_fifo_rst) |-> $past(i_reg_wr && i_reg_addr == CTRL_OFFSET
            && i_reg_wdata[CTRL_TX_RST]);
    endproperty
    a_tx_rst: assert property (p_tx_rst) else $error("tx reset without write");
    property p_hold;
        i_internal_receive_hold |-> o_receive_hold_output;
    endproperty
    a_hold: assert property (p_hold) else $error("hold output missing");
    property p_pop;
        o_lb_tx_pop |-> i_lb_tx_valid && !i_tx_enable && !i_rx_enable
            && !o_tx_fifo_rst && !o_rx_fifo_rst;
    endproperty
    a_pop: assert property (p_pop) else $error("loopback pop while not allowed");
    property p_rx_count;
        o_rx_data_count == i_rx_fifo_count + 32'(i_rx_pipe_count);
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("rx data count wrong");
    property p_tx_urg;
        o_tx_dma_urgent |-> i_tx_chain_count < i_tx_ae_level;
    endproperty
    a_tx_urg: assert property (p_tx_urg) else $error("tx urgent not almost empty");
    property p_rx_urg;
        o_rx_dma_urgent |-> i_rx_chain_count >= i_rx_af_level;
    endproperty
    a_rx_urg: assert property (p_rx_urg) else $error("rx urgent not almost full");
endmodule
bind fifo_dma_channel_ctrl_status fifo_dma_channel_ctrl_status_checker i_checker (.*);

// ### bench/rx_fifo_sink_model.sv
`timescale 1ns/10ps
module rx_fifo_sink_model (
    // Clock and word stream
    input  wire logic        i_clk,
    input  wire logic        i_valid,
    input  wire logic [31:0] i_data,
    output logic             o_ready
);
    logic [31:0] got[$];
    initial o_ready = 1'b0;
    // Random stalls act as an RX FIFO going full now and then
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            got.push_back(i_data);
        end
        #1 o_ready = ($urandom % 3) != 0;
    end
endmodule

// ### bench/fifo_dma_channel_ctrl_status_tb.sv
`timescale 1ns/10ps
module fifo_dma_channel_ctrl_status_tb;
    import chan_ctrl_pkg::*;
    logic        i_clk = 0, i_rst = 1, i_ce = 1, i_reg_wr = 0, i_reg_rd = 0;
    logic [7:0]  i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = '0, i_tx_chain_count = '0, i_rx_chain_count = '0;
    logic [31:0] i_rx_fifo_count = '0, i_tx_ae_level = '0, i_rx_af_level = '0;
    logic [31:0] i_lb_tx_data = '0, o_reg_rdata, o_rx_data_count, o_lb_rx_data, rv, w[8];
    logic [2:0]  i_rx_pipe_count = '0;
    fifo_flags_t i_flags = '0;
    dma_evt_t    i_dma = '0;
    logic i_rx_load_wr = 0, i_tx_enable = 0, i_rx_enable = 0, i_transmit_sm_idle = 0;
    logic i_receive_sm_idle = 0, i_tx_ref_locked = 0, i_internal_receive_hold = 0;
    logic i_sdram_busy = 0, i_sdram_init_done = 0, i_lb_tx_valid = 0, i_lb_rx_ready, p;
    logic o_reg_rvalid, o_tx_dma_urgent, o_rx_dma_urgent, o_irq, o_tx_fifo_rst;
    logic o_rx_fifo_rst, o_clock_monitor_rst, o_receive_hold_output, o_sdram_init_start;
    logic o_mem_a_param_sel, o_tx_direct_mover_enable, o_rx_direct_mover_enable;
    logic o_lb_tx_pop, o_lb_rx_valid;
    int bad_count = 0, n_checks = 0, cyc = 0, i, k;
    int sb[6] = '{14, 15, 12, 13, 19, 16};

    fifo_dma_channel_ctrl_status i_fifo_dma_channel_ctrl_status (.*);
    rx_fifo_sink_model i_rx_fifo_sink_model (.i_clk(i_clk), .i_valid(o_lb_rx_valid),
        .i_data(o_lb_rx_data), .o_ready(i_lb_rx_ready));

    initial forever #50 i_clk = ~i_clk;
    // Hang guard, well above the run length
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("unexpected at %0t: timeout", $time);
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        n_checks++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // Strobe drops and one idle edge passes, so calls may follow at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_reg_wr = 1; i_reg_addr = a; i_reg_wdata = d;
        @(posedge i_clk); #1 i_reg_wr = 0;
        @(posedge i_clk); #1;
    endtask
    task automatic rd(input logic [7:0] a);
        i_reg_rd = 1; i_reg_addr = a;
        @(posedge i_clk); #1 i_reg_rd = 0;
        chk(o_reg_rvalid, 1, "no read answer");
        rv = o_reg_rdata;
        @(posedge i_clk); #1;
    endtask
    // Live status bits; enables are zero so irq and gated bits read zero
    function automatic logic [31:0] exp_live();
        exp_live = '0;
        exp_live[ST_TX_EMPTY] = i_flags.tx_dma_empty & i_flags.sdram_tx_empty
            & i_flags.sdram_io_tx_empty & i_flags.tx_io_empty;
        exp_live[ST_TX_AEMPTY] = i_tx_chain_count < i_tx_ae_level;
        exp_live[ST_TX_FULL] = i_flags.tx_dma_full;
        exp_live[ST_RX_EMPTY] = i_flags.rx_dma_empty;
        exp_live[ST_RX_AFULL] = i_rx_chain_count >= i_rx_af_level;
        exp_live[ST_RX_FULL] = i_flags.rx_dma_full;
        exp_live[ST_DMA_IN_IDLE] = i_dma.dma_in_idle;
        exp_live[ST_DMA_OUT_IDLE] = i_dma.dma_out_idle;
        exp_live[ST_TX_SM_IDLE] = i_transmit_sm_idle;
        exp_live[ST_RX_SM_IDLE] = i_receive_sm_idle;
        exp_live[ST_LOCKED] = i_tx_ref_locked;
    endfunction
    task automatic rand_counts(input int corner);
        i_tx_ae_level = $urandom_range(0, 9);
        i_rx_af_level = $urandom_range(0, 9);
        i_tx_chain_count = corner ? i_tx_ae_level : $urandom_range(0, 9);
        i_rx_chain_count = corner ? i_rx_af_level : $urandom_range(0, 9);
    endtask

    initial begin
        void'($urandom(93));
        repeat (4) @(posedge i_clk);
        #1 i_rst = 0;
        rd(CTRL_OFFSET); chk(rv, CTRL_RESET, "control reset value");
        rd(8'h58); chk(rv, 0, "unmapped read");
        for (k = 0; k < 4; k++) begin
            rv = $urandom & CTRL_RW_MASK;
            wr(CTRL_OFFSET, rv);
            chk(o_tx_fifo_rst, rv[CTRL_TX_RST], "tx fifo reset");
            chk(o_rx_fifo_rst, rv[CTRL_RX_RST], "rx fifo reset");
            chk(o_receive_hold_output, rv[CTRL_FORCE_HOLD], "hold out");
            chk(o_rx_direct_mover_enable, rv[CTRL_RX_DIRECT], "rx direct");
            chk(o_tx_direct_mover_enable, rv[CTRL_TX_DIRECT], "tx direct");
            w[0] = rv;
            rd(CTRL_OFFSET); chk(rv, w[0], "control read back");
        end
        wr(CTRL_OFFSET, 0);
        i_internal_receive_hold = 1;
        rd(STATUS_OFFSET); chk(o_receive_hold_output, 1, "hold or");
        $display("test control done");
        for (k = 0; k < 8; k++) begin
            i_flags = fifo_flags_t'(7'($urandom));
            i_dma = dma_evt_t'({4'h0, 2'($urandom)});
            {i_transmit_sm_idle, i_receive_sm_idle, i_tx_ref_locked} = 3'($urandom);
            i_rx_fifo_count = $urandom_range(0, 600);
            i_rx_pipe_count = (k == 0) ? 3'h4 : 3'($urandom_range(0, 4));
            rand_counts(k == 0);
            rd(STATUS_OFFSET);
            chk(rv & 32'hC1F0_0377, exp_live(), "status word");
            chk(o_rx_data_count, i_rx_fifo_count + i_rx_pipe_count, "rx count");
        end
        $display("test status done");
        for (k = 0; k < 4; k++) begin
            rand_counts(k == 3);
            wr(CTRL_OFFSET, 32'(k) << CTRL_IN_BOOST);
            chk(o_tx_dma_urgent, k[0] & (i_tx_chain_count < i_tx_ae_level), "tx urg");
            chk(o_rx_dma_urgent, k[1] & (i_rx_chain_count >= i_rx_af_level), "rx urg");
        end
        $display("test urgent done");
        wr(CTRL_OFFSET, 0);
        i_flags.rx_dma_full = 1;
        i_flags.tx_io_empty = 0;
        for (k = 0; k < 6; k++) begin
            if (k < 4) i_dma = dma_evt_t'(6'h20 >> k);
            else if (k == 4) i_rx_load_wr = 1;
            else i_flags = fifo_flags_t'(i_flags | 7'h78);
            @(posedge i_clk); #1 i_dma = '0; i_rx_load_wr = 0;
            if (k == 0) chk(o_irq, 0, "irq while disabled");
            rd(STATUS_OFFSET); chk(rv[sb[k]], 1, "latch set");
            wr(STATUS_OFFSET, ~(32'h1 << sb[k]));
            rd(STATUS_OFFSET); chk(rv[sb[k]], 1, "latch kept");
            if (k == 0) begin
                wr(CTRL_OFFSET, 32'h1 << CTRL_RD_DMA_IE);
                chk(o_irq, 0, "irq other enable");
                wr(CTRL_OFFSET, 32'h1 << CTRL_WR_DMA_IE);
                chk(o_irq, 1, "irq enabled");
            end
            wr(STATUS_OFFSET, 32'h1 << sb[k]);
            rd(STATUS_OFFSET); chk(rv[sb[k]], 0, "latch cleared");
        end
        chk(o_irq, 0, "irq after clear");
        wr(CTRL_OFFSET, 32'h1 << CTRL_FORCE_IRQ);
        chk(o_irq, 0, "force alone");
        wr(CTRL_OFFSET, 32'h18);
        rd(STATUS_OFFSET); chk({o_irq, rv[ST_IRQ]}, 2'b11, "forced irq");
        $display("test latches done");
        i_sdram_busy = 1;
        wr(CTRL_OFFSET, 32'h1 << CTRL_SDRAM_INIT);
        rd(CTRL_OFFSET); chk(rv[CTRL_SDRAM_INIT], 0, "init while busy");
        i_sdram_busy = 0;
        wr(CTRL_OFFSET, 32'h1 << CTRL_SDRAM_INIT);
        rd(CTRL_OFFSET); chk({rv[16], o_mem_a_param_sel}, 2'b11, "init set");
        i_sdram_init_done = 1;
        @(posedge i_clk); #1 i_sdram_init_done = 0;
        rd(CTRL_OFFSET); chk({rv[16], o_mem_a_param_sel}, 0, "init clear");
        $display("test init done");
        i_tx_ref_locked = 1;
        wr(CTRL_OFFSET, 32'h1 << CTRL_MON_RST);
        chk(o_clock_monitor_rst, 1, "monitor reset bit");
        wr(CTRL_OFFSET, 0);
        repeat (4) @(posedge i_clk);
        #1 i_tx_ref_locked = 0;
        repeat (RETRY_CYCLES) @(posedge i_clk);
        #1 chk(o_clock_monitor_rst, 0, "retry too early");
        @(posedge i_clk); #1 chk(o_clock_monitor_rst, 1, "lock retry");
        repeat (MON_PULSE_CYCLES) @(posedge i_clk);
        #1 chk(o_clock_monitor_rst, 0, "retry pulse end");
        i_tx_ref_locked = 1;
        $display("test monitor done");
        wr(CTRL_OFFSET, 32'h1 << CTRL_LOOPBACK);
        i_tx_enable = 1; i_lb_tx_valid = 1;
        @(posedge i_clk); #1 chk(o_lb_tx_pop, 0, "pop while tx on");
        i_tx_enable = 0;
        for (i = 0; i < 8; i++) begin
            w[i] = (i == 0) ? 32'hFFFF_FFFF : $urandom;
            i_lb_tx_data = w[i];
            do begin
                #1 p = o_lb_tx_pop;
                @(posedge i_clk); #1;
            end while (p !== 1'b1);
        end
        i_lb_tx_valid = 0;
        for (k = 0; k < 50 && i_rx_fifo_sink_model.got.size() < 8; k++) @(posedge i_clk);
        chk(i_rx_fifo_sink_model.got.size(), 8, "loopback count");
        for (i = 0; i < 8 && i < i_rx_fifo_sink_model.got.size(); i++)
            chk(i_rx_fifo_sink_model.got[i], w[i], "loopback word");
        $display("test loopback done");
        end_of_test();
    end
endmodule
